// >>> design/failsafe_powerup_state_controller.sv
// Behaviour
// RULE_01: off state keeps only wake detection
// RULE_02: clear-wake command or global fault enters off
// RULE_03: latch off causes, copy at power-up
// RULE_04: inhibit needs new wake rising edge
// RULE_05: inhibit cleared on battery loss, set by command
// RULE_06: wake continues only with supply, no overtemp
// RULE_07: off drives reset and safing outputs low
// RULE_08: init enables internal regulators first
// RULE_09: clock fault or overvoltage holds core reset
// RULE_10: init goes to reset at core release
// RULE_11: download config, crc mismatch goes off
// RULE_12: wait overtemp clear, else reset timeout off
// RULE_13: power-up analog test gates switchers
// RULE_14: extension length 2 to 32 ms
// RULE_15: extension runs analog then logic tests
// RULE_16: failed test enters safe after extension
// RULE_17: reset state keeps monitors, not watchdog
// RULE_18: operating global reset re-enters reset state
// RULE_19: auto test disable skips tests after operation
// RULE_20: overtemp monitor disabled only when off
// RULE_21: primary step-down re-enable waits cool
// RULE_22: entering reset from operation restores defaults
`timescale 1ns/1ps
`include "fsc_cfg.svh"
module failsafe_powerup_state_controller
   import fsc_pkg::*;
#(
   parameter int STARTUP_TO_CYCLES = `STARTUP_TO_CYC,
   parameter int RESET_TO_CYCLES = `RESET_TO_CYC,
   parameter int MS_CYCLES = `MS_CYC
) (
   input wire logic mclk_i, // 25 mhz system clock
   input wire logic reset_n_i, // sync reset, active low
   input wire logic battery_lost_i, // reset followed loss of all supplies
   input wire logic wake_pin_i, // ignition request pin
   input wire logic vin_ok_i, // supply above power-up minimum
   input wire logic supply_overvoltage_flag_i, // supply overvoltage
   input wire logic clk_fault_i, // system clock fault
   input wire logic over_temp_i, // die above warning minus hysteresis
   input wire logic step_down_hot_i, // primary step-down above warning
   input wire logic internal_regulator_supply_ov_i, // valid internal regulator overvoltage
   input wire logic core_ready_i, // core supplies and clock good
   input wire logic nv_done_i, // nonvolatile download finished
   input wire logic nv_crc_ok_i, // download crc matches
   input wire logic pu_test_done_i, // power-up analog test done
   input wire logic pu_test_pass_i, // power-up analog test passed
   input wire logic regs_uv_ok_i, // all regulators above uv
   input wire logic ext_test_done_i, // extension self-tests done
   input wire logic ext_test_pass_i, // extension self-tests passed
   input wire logic global_reset_i, // global reset condition
   input wire logic global_off_i, // global power-down condition
   input wire logic [3:0] addr_i, // register address
   input wire logic [7:0] wdata_i, // write data
   input wire logic wr_i, // write strobe
   input wire logic rd_i, // read strobe
   output logic [7:0] rdata_o, // read data, cycle after strobe
   output logic wake_det_en_o, // wake detector enable
   output logic int_reg_en_o, // internal regulators enable
   output logic core_por_n_o, // core power-on reset, low asserted
   output logic nv_load_o, // nonvolatile download request
   output logic pu_test_run_o, // power-up analog test run
   output logic switchers_en_o, // switching regulators enable
   output logic step_down_en_o, // primary step-down enable
   output logic ext_test_run_o, // extension self-test run
   output logic monitors_en_o, // monitoring and protection on
   output logic ot_mon_en_o, // overtemperature monitoring on
   output logic watchdog_en_o, // watchdog enabled
   output logic cfg_default_o, // pulse: restore configuration defaults
   output logic system_reset_n_o, // system reset out, low asserted
   output logic safing_irq_n_o, // safing enable / interrupt out
   output logic safe_req_o // pulse: enter safe state
);
   fsc_state_e state_q, state_d;
   logic wake_lvl, wake_prev_q, wake_rise;
   logic inhibit_q, armed_q, wake_latch_q, after_oper_q, test_fail_q;
   logic [`CAUSE_W-1:0] aon_latch_q, status_q;
   logic [7:0] cfg_q, rdata_q;
   logic [31:0] tmr_q, ext_cnt_q;
   logic [2:0] phase_q;
   logic ext_done, startup_to, reset_to, cmd_clr_wake, go_off;
   logic [`CAUSE_W-1:0] cause_set;

   // extension length: 2 ms plus 10 ms per step
   function automatic logic [31:0] ext_cycles(input logic [1:0] sel);
      ext_cycles = 32'(`EXT_BASE_MS + `EXT_STEP_MS * int'(sel)) * 32'(MS_CYCLES);
   endfunction

   pin_filter u_wake (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .pin_i(wake_pin_i),
      .level_o(wake_lvl)
   );

   // command decode
   assign cmd_clr_wake = wr_i && addr_i == `ADDR_CTRL && wdata_i[`CTRL_CLR_WAKE];
   assign wake_rise = wake_lvl && !wake_prev_q;
   assign startup_to = state_q == ST_INIT && tmr_q >= 32'(STARTUP_TO_CYCLES);
   assign reset_to = (state_q == ST_PREP || state_q == ST_DOWNLOAD)
      && tmr_q >= 32'(RESET_TO_CYCLES);
   assign ext_done = state_q == ST_EXTEND && ext_cnt_q >= ext_cycles(cfg_q[1:0]); // RULE_14

   // causes that send the device to off
   always_comb begin
      cause_set = '0;
      if (state_q == ST_OFF && wake_latch_q) begin
         cause_set[`CAUSE_VIN_UV] = !vin_ok_i; // RULE_06
         cause_set[`CAUSE_OT] = over_temp_i; // RULE_06
      end
      cause_set[`CAUSE_STARTUP_TO] = startup_to; // RULE_09
      cause_set[`CAUSE_CRC] = state_q == ST_DOWNLOAD && nv_done_i && !nv_crc_ok_i; // RULE_11
      cause_set[`CAUSE_RESET_TO] = reset_to; // RULE_12 RULE_21
      cause_set[`CAUSE_CMD] = cmd_clr_wake && state_q != ST_OFF; // RULE_02
      cause_set[`CAUSE_GLOBAL] = global_off_i && state_q != ST_OFF; // RULE_02
   end
   assign go_off = |cause_set;

   // next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_OFF: begin
            if (wake_latch_q && vin_ok_i && !over_temp_i) state_d = ST_INIT; // RULE_06
         end
         ST_INIT: begin
            // clock fault or overvoltage keeps core reset until timeout
            if (core_ready_i && !clk_fault_i && !supply_overvoltage_flag_i) state_d = ST_DOWNLOAD; // RULE_10
         end
         ST_DOWNLOAD: begin
            if (nv_done_i && nv_crc_ok_i) state_d = ST_PREP; // RULE_11
         end
         ST_PREP: begin
            // cool die, passing power-up test, then regulators up
            if (!over_temp_i && !step_down_hot_i && phase_q[2] && regs_uv_ok_i && !global_reset_i)
               state_d = ST_EXTEND; // RULE_12 RULE_14 RULE_21
         end
         ST_EXTEND: begin
            if (global_reset_i) state_d = ST_PREP; // RULE_18
            else if (ext_done) state_d = ST_OPER;
         end
         ST_OPER: begin
            if (global_reset_i) state_d = ST_PREP; // RULE_18
         end
         default: state_d = ST_OFF;
      endcase
      if (go_off) state_d = ST_OFF; // RULE_02
   end

   // state, timers and phase of the reset state
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         state_q <= ST_OFF;
         tmr_q <= '0;
         ext_cnt_q <= '0;
         phase_q <= '0;
         after_oper_q <= 1'b0;
         test_fail_q <= 1'b0;
      end else begin
         state_q <= state_d;
         tmr_q <= (state_d != state_q) ? 32'h0 : tmr_q + 32'h1;
         ext_cnt_q <= (state_q == ST_EXTEND && state_d == ST_EXTEND) ? ext_cnt_q + 32'h1 : 32'h0;
         if (state_q == ST_OPER && state_d == ST_PREP) after_oper_q <= 1'b1;
         else if (state_q == ST_DOWNLOAD) after_oper_q <= 1'b0;
         // phase: 1 test running, 2 failed and held, 4 switchers allowed
         // holding 4 through extension and operation keeps switchers up on re-entry
         if (state_q != ST_PREP) begin
            phase_q <= (state_q == ST_EXTEND || state_q == ST_OPER) ? 3'h4 : 3'h0; // RULE_18
         end else if (!over_temp_i && phase_q == 3'h0) begin
            phase_q <= 3'h1; // RULE_13
         end else if (phase_q[0] && pu_test_done_i) begin
            phase_q <= pu_test_pass_i ? 3'h4 : 3'h2; // RULE_13
         end
         if (state_d == ST_EXTEND && state_q != ST_EXTEND) test_fail_q <= 1'b0;
         else if (state_q == ST_EXTEND && ext_test_done_i && !ext_test_pass_i)
            test_fail_q <= 1'b1; // RULE_16
      end
   end

   // wake hold, edge tracking and restart inhibit
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         wake_prev_q <= 1'b0;
         wake_latch_q <= 1'b0;
         armed_q <= 1'b1;
         inhibit_q <= 1'b0;
      end else begin
         wake_prev_q <= wake_lvl;
         if (battery_lost_i) inhibit_q <= 1'b0; // RULE_05
         if ((wr_i && addr_i == `ADDR_CTRL && wdata_i[`CTRL_CLR_INHIBIT]))
            inhibit_q <= 1'b0;
         if ((wr_i && addr_i == `ADDR_CTRL && wdata_i[`CTRL_SET_INHIBIT]) || internal_regulator_supply_ov_i)
            inhibit_q <= 1'b1; // RULE_05
         if (state_d == ST_OFF && state_q != ST_OFF) begin
            wake_latch_q <= 1'b0; // RULE_06
            armed_q <= !(inhibit_q && wake_lvl); // RULE_04
         end else if (state_q == ST_OFF) begin
            if (wake_latch_q && state_d == ST_OFF) wake_latch_q <= 1'b0; // RULE_06
            else if (wake_lvl && (armed_q || wake_rise)) wake_latch_q <= 1'b1; // RULE_04
            if (wake_rise) armed_q <= 1'b1; // RULE_04
         end
      end
   end

   // always-on cause latch, copied to status at each power-up
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         aon_latch_q <= '0;
         status_q <= '0;
      end else begin
         if (battery_lost_i) aon_latch_q <= '0;
         else aon_latch_q <= aon_latch_q | cause_set; // RULE_03
         if (state_q == ST_INIT && state_d == ST_DOWNLOAD) status_q <= aon_latch_q | cause_set; // RULE_03
         else if (wr_i && addr_i == `ADDR_CTRL && wdata_i[`CTRL_CLR_LATCH])
            status_q <= cause_set;
      end
   end

   // configuration, extension length cleared on operating re-entry
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         cfg_q <= `CFG_RESET;
      end else if (state_q == ST_OPER && state_d == ST_PREP) begin
         cfg_q <= {cfg_q[7:3], cfg_q[`CFG_AUTO_SELFTEST_DISABLE], 2'b00}; // RULE_22
      end else if (wr_i && addr_i == `ADDR_CFG) begin
         cfg_q <= wdata_i;
      end
   end

   // read mux, unmapped reads zero
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) rdata_q <= '0;
      else if (!rd_i) rdata_q <= '0;
      else case (addr_i)
         `ADDR_CFG: rdata_q <= cfg_q;
         `ADDR_STAT: rdata_q <= {5'h0, wake_latch_q, armed_q, inhibit_q};
         `ADDR_LATCH: rdata_q <= {1'b0, status_q};
         `ADDR_STATE: rdata_q <= {2'b0, state_q};
         default: rdata_q <= '0;
      endcase
   end

   // registered outputs, all low in the off state except wake_det_en_o
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         wake_det_en_o <= 1'b1;
         int_reg_en_o <= 1'b0;
         core_por_n_o <= 1'b0;
         nv_load_o <= 1'b0;
         pu_test_run_o <= 1'b0;
         switchers_en_o <= 1'b0;
         step_down_en_o <= 1'b0;
         ext_test_run_o <= 1'b0;
         monitors_en_o <= 1'b0;
         ot_mon_en_o <= 1'b0;
         watchdog_en_o <= 1'b0;
         cfg_default_o <= 1'b0;
         system_reset_n_o <= 1'b0;
         safing_irq_n_o <= 1'b0;
         safe_req_o <= 1'b0;
      end else begin
         wake_det_en_o <= 1'b1; // RULE_01
         int_reg_en_o <= state_d != ST_OFF; // RULE_08
         core_por_n_o <= state_d != ST_OFF && state_d != ST_INIT; // RULE_09
         nv_load_o <= state_d == ST_DOWNLOAD; // RULE_11
         pu_test_run_o <= state_d == ST_PREP && phase_q[0]; // RULE_13
         switchers_en_o <= (state_d == ST_PREP && phase_q[2]) || state_d == ST_EXTEND
            || state_d == ST_OPER; // RULE_13 RULE_18
         step_down_en_o <= ((state_d == ST_PREP && phase_q[2] && !step_down_hot_i)
            || state_d == ST_EXTEND || state_d == ST_OPER); // RULE_21
         ext_test_run_o <= state_d == ST_EXTEND && !ext_test_done_i
            && !(after_oper_q && cfg_q[`CFG_AUTO_SELFTEST_DISABLE]); // RULE_15 RULE_19
         monitors_en_o <= state_d != ST_OFF && state_d != ST_INIT; // RULE_17
         ot_mon_en_o <= state_d != ST_OFF; // RULE_20
         watchdog_en_o <= state_d == ST_OPER; // RULE_17
         cfg_default_o <= state_q == ST_OPER && state_d == ST_PREP; // RULE_22
         system_reset_n_o <= state_d == ST_OPER; // RULE_07 RULE_18
         safing_irq_n_o <= state_d == ST_OPER; // RULE_07 RULE_18
         safe_req_o <= ext_done && !go_off && test_fail_q; // RULE_16
      end
   end

   assign rdata_o = rdata_q;
endmodule

// >>> design/fsc_cfg.svh
`ifndef FSC_CFG_SVH
`define FSC_CFG_SVH
// register offsets (plain port, word index)
`define ADDR_CTRL 4'h0
`define ADDR_CFG 4'h1
`define ADDR_STAT 4'h2
`define ADDR_LATCH 4'h3
`define ADDR_STATE 4'h4
// control register fields (write-one pulses)
`define CTRL_CLR_WAKE 0
`define CTRL_SET_INHIBIT 1
`define CTRL_CLR_INHIBIT 2
`define CTRL_CLR_LATCH 3
// config fields
`define CFG_EXT_LO 0
`define CFG_EXT_HI 1
`define CFG_AUTO_SELFTEST_DISABLE 2
`define CFG_RESET 8'h00
// off-cause bits
`define CAUSE_VIN_UV 0
`define CAUSE_OT 1
`define CAUSE_STARTUP_TO 2
`define CAUSE_CRC 3
`define CAUSE_RESET_TO 4
`define CAUSE_CMD 5
`define CAUSE_GLOBAL 6
`define CAUSE_W 7
// timing
`define CLK_MHZ 25
`define EXT_BASE_MS 2
`define EXT_STEP_MS 10
`define STARTUP_TO_US 2000
`define RESET_TO_US 16000
`define STARTUP_TO_CYC (`STARTUP_TO_US * `CLK_MHZ)
`define RESET_TO_CYC (`RESET_TO_US * `CLK_MHZ)
`define MS_CYC (1000 * `CLK_MHZ)
`endif

// >>> design/fsc_pkg.sv
package fsc_pkg;
   typedef enum logic [5:0] {
      ST_OFF = 6'h01,
      ST_INIT = 6'h02,
      ST_DOWNLOAD = 6'h04,
      ST_PREP = 6'h08,
      ST_EXTEND = 6'h10,
      ST_OPER = 6'h20
   } fsc_state_e;
endpackage

// >>> design/pin_filter.sv
`timescale 1ns/1ps
// three-stage sampler: a change counts once stages two and three agree
module pin_filter (
   input wire logic mclk_i, // system clock
   input wire logic reset_n_i, // sync reset, active low
   input wire logic pin_i, // asynchronous pin
   output logic level_o // filtered level
);
   logic s1_q, s2_q, s3_q, level_q;

   // first stage feeds only the second
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) level_q <= s3_q;
      end
   end

   assign level_o = level_q;
endmodule

// >>> sim/fsc_chk.sv
`timescale 1ns/1ps
`include "fsc_cfg.svh"
// pin-level watcher; latencies follow the registered outputs
module fsc_chk (
   input wire logic mclk_i, // clock
   input wire logic reset_n_i, // reset
   input wire logic [3:0] addr_i, // address
   input wire logic [7:0] wdata_i, // data
   input wire logic wr_i, // write
   input wire logic clk_fault_i, // clock fault
   input wire logic supply_overvoltage_flag_i, // overvoltage
   input wire logic pu_test_pass_i, // test pass
   input wire logic global_reset_i, // global reset
   input wire logic wake_det_en_o, // wake detect
   input wire logic int_reg_en_o, // regulators
   input wire logic core_por_n_o, // core reset
   input wire logic switchers_en_o, // switchers
   input wire logic monitors_en_o, // monitors
   input wire logic ot_mon_en_o, // temp monitor
   input wire logic watchdog_en_o, // watchdog
   input wire logic cfg_default_o, // defaults
   input wire logic system_reset_n_o, // reset out
   input wire logic safing_irq_n_o // safing out
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   // control write carrying the clear-wake bit
   sequence s_clr_wake; wr_i && addr_i == `ADDR_CTRL && wdata_i[`CTRL_CLR_WAKE]; endsequence
   // core still held while a start-up fault is present
   sequence s_por_fault; !core_por_n_o && (clk_fault_i || supply_overvoltage_flag_i); endsequence
   // only the operating state has the reset pin released
   sequence s_oper_reset; global_reset_i && system_reset_n_o; endsequence
   property p_wake_det; wake_det_en_o; endproperty
   property p_off_pins; !int_reg_en_o |-> !system_reset_n_o && !safing_irq_n_o; endproperty
   property p_clr_wake; s_clr_wake |-> ##[1:3] !int_reg_en_o; endproperty
   property p_por_hold; s_por_fault |=> !core_por_n_o; endproperty
   property p_reg_order; switchers_en_o |-> int_reg_en_o; endproperty
   property p_sw_gate; $rose(switchers_en_o) |-> $past(pu_test_pass_i); endproperty
   property p_reset_mon;
      !system_reset_n_o && core_por_n_o |-> monitors_en_o && !watchdog_en_o;
   endproperty
   property p_ot_mon; int_reg_en_o |-> ot_mon_en_o; endproperty
   // switchers stay up across a reset taken from operation
   property p_glob_rst;
      s_oper_reset |=> !system_reset_n_o && !safing_irq_n_o && switchers_en_o;
   endproperty
   property p_cfg_pulse; cfg_default_o |-> !system_reset_n_o ##1 !cfg_default_o; endproperty
   a_wake_det: assert property (p_wake_det) else $error("wake detector off");
   a_off_pins: assert property (p_off_pins) else $error("pins high while off");
   a_clr_wake: assert property (p_clr_wake) else $error("clear wake ignored");
   a_por_hold: assert property (p_por_hold) else $error("core reset released");
   a_reg_order: assert property (p_reg_order) else $error("switcher before internal_regulator_supply");
   a_sw_gate: assert property (p_sw_gate) else $error("switchers without pass");
   a_reset_mon: assert property (p_reset_mon) else $error("monitor set wrong");
   a_ot_mon: assert property (p_ot_mon) else $error("temp monitor off");
   a_glob_rst: assert property (p_glob_rst) else $error("global reset missed");
   a_cfg_pulse: assert property (p_cfg_pulse) else $error("defaults pulse bad");
endmodule
bind failsafe_powerup_state_controller fsc_chk u_chk (.mclk_i, .reset_n_i, .addr_i, .wdata_i,
   .wr_i, .clk_fault_i, .supply_overvoltage_flag_i, .pu_test_pass_i, .global_reset_i, .wake_det_en_o,
   .int_reg_en_o, .core_por_n_o, .switchers_en_o, .monitors_en_o, .ot_mon_en_o,
   .watchdog_en_o, .cfg_default_o, .system_reset_n_o, .safing_irq_n_o);

// >>> sim/fsc_plant.sv
`timescale 1ns/1ps
// far side: supplies, nonvolatile store and self-test engines
module fsc_plant (
   input wire logic mclk_i, // clock
   input wire logic int_reg_en_i, // internal_regulator_supply on
   input wire logic nv_load_i, // download
   input wire logic pu_test_run_i, // power-up test
   input wire logic switchers_en_i, // switchers on
   input wire logic ext_test_run_i, // ext test
   input wire logic crc_bad_i, // corrupt store
   input wire logic ext_bad_i, // failing test
   output logic core_ready_o = 1'b0, // core good
   output logic nv_done_o = 1'b0, // loaded
   output logic nv_crc_ok_o = 1'b0, // crc ok
   output logic pu_test_done_o = 1'b0, // test done
   output logic pu_test_pass_o = 1'b0, // test pass
   output logic regs_uv_ok_o = 1'b0, // above uv
   output logic ext_test_done_o = 1'b0, // ext done
   output logic ext_test_pass_o = 1'b0 // ext pass
);
   // answers trail requests, so a dropped request drops the answer too
   always @(posedge mclk_i) begin
      core_ready_o <= int_reg_en_i;
      nv_done_o <= nv_load_i;
      nv_crc_ok_o <= nv_load_i && !crc_bad_i;
      pu_test_done_o <= pu_test_run_i;
      pu_test_pass_o <= pu_test_run_i;
      regs_uv_ok_o <= switchers_en_i;
      ext_test_done_o <= ext_test_run_i;
      ext_test_pass_o <= ext_test_run_i && !ext_bad_i;
   end
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
`include "fsc_cfg.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
// bounded wait; running out ends the run
`define WAIT(c) begin n = 0; while (!(c) && n < 3000) begin @(posedge mclk_i); #1 n++; end \
   if (n >= 3000) begin miscompares++; summarize(); end end
module tb;
   import fsc_pkg::*;
   localparam int MS = 10;
   logic mclk_i, reset_n_i, battery_lost_i, wake_pin_i, vin_ok_i, supply_overvoltage_flag_i, clk_fault_i;
   logic over_temp_i, step_down_hot_i, internal_regulator_supply_ov_i, global_reset_i, global_off_i, wr_i, rd_i;
   logic core_ready_i, nv_done_i, nv_crc_ok_i, pu_test_done_i, pu_test_pass_i, regs_uv_ok_i;
   logic ext_test_done_i, ext_test_pass_i, crc_bad, ext_bad;
   logic [3:0] addr_i;
   logic [7:0] wdata_i, rdata_o, d;
   logic wake_det_en_o, int_reg_en_o, core_por_n_o, nv_load_o, pu_test_run_o, switchers_en_o;
   logic step_down_en_o, ext_test_run_o, monitors_en_o, ot_mon_en_o, watchdog_en_o;
   logic cfg_default_o, system_reset_n_o, safing_irq_n_o, safe_req_o;
   int total_checks = 0, miscompares = 0, n, e, ext_cnt;
   bit cfg_seen, safe_seen, run_seen;
   failsafe_powerup_state_controller #(.STARTUP_TO_CYCLES(50), .RESET_TO_CYCLES(200),
      .MS_CYCLES(MS)) dut (.mclk_i, .reset_n_i, .battery_lost_i, .wake_pin_i, .vin_ok_i,
      .supply_overvoltage_flag_i, .clk_fault_i, .over_temp_i, .step_down_hot_i, .internal_regulator_supply_ov_i, .core_ready_i,
      .nv_done_i, .nv_crc_ok_i, .pu_test_done_i, .pu_test_pass_i, .regs_uv_ok_i,
      .ext_test_done_i, .ext_test_pass_i, .global_reset_i, .global_off_i, .addr_i, .wdata_i,
      .wr_i, .rd_i, .rdata_o, .wake_det_en_o, .int_reg_en_o, .core_por_n_o, .nv_load_o,
      .pu_test_run_o, .switchers_en_o, .step_down_en_o, .ext_test_run_o, .monitors_en_o,
      .ot_mon_en_o, .watchdog_en_o, .cfg_default_o, .system_reset_n_o, .safing_irq_n_o,
      .safe_req_o);
   fsc_plant plant (.mclk_i, .int_reg_en_i(int_reg_en_o), .nv_load_i(nv_load_o),
      .pu_test_run_i(pu_test_run_o), .switchers_en_i(switchers_en_o),
      .ext_test_run_i(ext_test_run_o), .crc_bad_i(crc_bad), .ext_bad_i(ext_bad),
      .core_ready_o(core_ready_i), .nv_done_o(nv_done_i), .nv_crc_ok_o(nv_crc_ok_i),
      .pu_test_done_o(pu_test_done_i), .pu_test_pass_o(pu_test_pass_i),
      .regs_uv_ok_o(regs_uv_ok_i), .ext_test_done_o(ext_test_done_i),
      .ext_test_pass_o(ext_test_pass_i));
   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end
   // sticky flags, sampled before the edge updates land
   always @(posedge mclk_i) begin
      if (switchers_en_o && !system_reset_n_o) ext_cnt++;
      if (cfg_default_o) cfg_seen = 1'b1;
      if (safe_req_o) safe_seen = 1'b1;
      if (ext_test_run_o) run_seen = 1'b1;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic rc(input logic [3:0] a, input logic [7:0] x, input string nm);
      rd(a);
      `CHK(nm, x, d)
   endtask
   task automatic boot();
      @(posedge mclk_i);
      wake_pin_i <= 1'b1;
      `WAIT(system_reset_n_o === 1'b1)
      wake_pin_i <= 1'b0;
   endtask
   task automatic down();
      wr(`ADDR_CTRL, 8'h01);
      `WAIT(int_reg_en_o === 1'b0)
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      {battery_lost_i, wake_pin_i, supply_overvoltage_flag_i, clk_fault_i, over_temp_i, step_down_hot_i} = '0;
      {internal_regulator_supply_ov_i, global_reset_i, global_off_i, wr_i, rd_i, crc_bad, ext_bad} = '0;
      {reset_n_i, addr_i, wdata_i} = '0;
      vin_ok_i = 1'b1;
      repeat (4) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      rc(`ADDR_STATE, 8'(ST_OFF), "state");
      `CHK("wake det", 1'b1, wake_det_en_o)
      rc(`ADDR_CFG, `CFG_RESET, "cfg");
      rc(4'hf, 8'h00, "unmapped");
      $display("test reset done");
      // every extension code, each boot ended by a clear-wake command
      for (int s = 0; s < 4; s++) begin
         wr(`ADDR_CFG, 8'(s));
         {ext_cnt, safe_seen} = '0;
         boot();
         e = (`EXT_BASE_MS + `EXT_STEP_MS * s) * MS;
         `CHK("ext len", 1'b1, ext_cnt >= e && ext_cnt <= e + 4)
         `CHK("no safe", 1'b0, safe_seen)
         `CHK("step on", 1'b1, step_down_en_o)
         rd(`ADDR_LATCH);
         if (s > 0) `CHK("cmd cause", 1'b1, d[`CAUSE_CMD])
         down();
         rc(`ADDR_STATE, 8'(ST_OFF), "off");
      end
      $display("test extension done");
      // each fault blocks or aborts power-up; its cause shows after the next boot
      for (int k = 0; k < 5; k++) begin
         @(posedge mclk_i);
         vin_ok_i <= (k != 0);
         over_temp_i <= (k == 1);
         clk_fault_i <= (k == 2);
         crc_bad <= (k == 3);
         step_down_hot_i <= (k == 4);
         wake_pin_i <= 1'b1;
         if (k < 2) repeat (10) @(posedge mclk_i);
         else `WAIT(int_reg_en_o === 1'b1)
         #1;
         `CHK("no init", k >= 2, int_reg_en_o)
         if (k == 4) `WAIT(switchers_en_o === 1'b1)
         if (k == 4) `CHK("step down held", 1'b0, step_down_en_o)
         wake_pin_i <= 1'b0;
         `WAIT(int_reg_en_o === 1'b0)
         {over_temp_i, clk_fault_i, crc_bad, step_down_hot_i} <= '0;
         vin_ok_i <= 1'b1;
         boot();
         rd(`ADDR_LATCH);
         `CHK("cause", 1'b1, d[k])
         down();
      end
      $display("test faults done");
      wr(`ADDR_CTRL, 8'h02);
      rd(`ADDR_STAT);
      `CHK("inhibit", 1'b1, d[0])
      @(posedge mclk_i);
      wake_pin_i <= 1'b1;
      `WAIT(system_reset_n_o === 1'b1)
      global_off_i <= 1'b1;
      `WAIT(int_reg_en_o === 1'b0)
      global_off_i <= 1'b0;
      repeat (20) @(posedge mclk_i);
      `CHK("no restart", 1'b0, int_reg_en_o)
      wake_pin_i <= 1'b0;
      repeat (10) @(posedge mclk_i);
      boot();
      `CHK("restart", 1'b1, system_reset_n_o)
      battery_lost_i <= 1'b1;
      @(posedge mclk_i);
      battery_lost_i <= 1'b0;
      rd(`ADDR_STAT);
      `CHK("inh lost", 1'b0, d[0])
      internal_regulator_supply_ov_i <= 1'b1;
      @(posedge mclk_i);
      internal_regulator_supply_ov_i <= 1'b0;
      rd(`ADDR_STAT);
      `CHK("inh internal_regulator_supply", 1'b1, d[0])
      wr(`ADDR_CTRL, 8'h04);
      wr(`ADDR_CTRL, 8'h08);
      rc(`ADDR_LATCH, 8'h00, "latch clr");
      $display("test inhibit done");
      // reset from operation with self-tests disabled
      wr(`ADDR_CFG, 8'h04);
      {cfg_seen, run_seen} = '0;
      @(posedge mclk_i);
      global_reset_i <= 1'b1;
      repeat (5) @(posedge mclk_i);
      #1;
      `CHK("reset pins", 3'b001, {system_reset_n_o, safing_irq_n_o, switchers_en_o})
      `CHK("defaults", 1'b1, cfg_seen)
      global_reset_i <= 1'b0;
      `WAIT(system_reset_n_o === 1'b1)
      `CHK("tests run", 1'b0, run_seen)
      down();
      wr(`ADDR_CFG, 8'h00);
      ext_bad <= 1'b1;
      {safe_seen, run_seen} = '0;
      boot();
      repeat (2) @(posedge mclk_i);
      `CHK("safe req", 1'b1, safe_seen)
      `CHK("ext tests", 1'b1, run_seen)
      $display("test reset paths done");
      summarize();
   end
   initial begin
      repeat (100000) @(posedge mclk_i);
      miscompares++;
      summarize();
   end
endmodule
